/* File: inc/gpcs_pkg.sv */
// Purpose: shared constants and types of the gigabit coding sublayer pair
// Assumes: one 50 MHz core clock on both ends
// Notes: code-groups are a simplified {kind, byte} form, not 8b/10b
package gpcs_pkg;
	// core clock rate and the auto-negotiation link timer
	localparam int CLK_MHZ = 50;
	localparam int LINK_TIME_US = 10000;
	localparam int LINK_CYCLES = LINK_TIME_US * CLK_MHZ;
	localparam int TIMER_W = 20;
	// word widths
	localparam int ABIL_W = 16;
	localparam int CG_W = 10;
	localparam int BYTE_W = 8;
	// code-group field positions
	localparam int KIND_MSB = 9;
	localparam int KIND_LSB = 8;
	// code-group kinds
	localparam logic [1:0] KIND_IDLE = 2'h0;
	localparam logic [1:0] KIND_DATA = 2'h1;
	localparam logic [1:0] KIND_CFG_LO = 2'h2;
	localparam logic [1:0] KIND_CFG_HI = 2'h3;
	// idle byte that carries a transmit error
	localparam logic [7:0] ERR_BYTE = 8'hFE;
	localparam logic [7:0] IDLE_BYTE = 8'h00;
	// acknowledge bit of the configuration word
	localparam int ACK_BIT = 14;
	// identical configuration words needed before acceptance
	localparam logic [1:0] CFG_MATCH = 2'h3;
	// reset values
	localparam logic [15:0] ABIL_RST = 16'h0000;
	localparam logic [9:0] CG_RST = 10'h000;
	// auto-negotiation states
	typedef enum logic [2:0] {
		AN_ENABLE_ST,
		AN_RESTART_ST,
		AN_ABILITY_ST,
		AN_ACK_ST,
		AN_COMPLETE_ACK_ST,
		AN_IDLE_ST,
		AN_LINK_GOOD_ST,
		AN_NO_NEG_GOOD_ST
	} gpcs_an_e;
endpackage : gpcs_pkg

/* File: inc/gpcs_if.sv */
// Purpose: connection between the coding sublayer and its MAC/management host
// Assumes: both ends clocked by the same core clock
// Notes: no clocking block; the bench joins the two ends here
`timescale 1ns/10ps
`default_nettype none
interface gpcs_if;
	// management controls from the host
	logic negotiation_enable;
	logic negotiation_restart;
	logic sublayer_main_reset;
	logic [15:0] local_ability_word;
	logic isolate;
	logic loopback;
	logic unidir;
	// transmit (G)MII from the host
	logic [7:0] txd;
	logic tx_en;
	logic tx_er;
	// register-access start and direction
	logic reg_request;
	logic reg_write;
	// status back to the host
	logic negotiation_done;
	logic [15:0] partner_ability_word;
	logic page_received_flag;
	logic negotiated_link_good;
	logic pll_loss;
	logic [15:0] reg_rdata;
	logic reg_rdata_valid;
	// receive (G)MII to the host
	logic [7:0] rxd;
	logic rx_dv;
	logic rx_er;
	modport dev (
		input negotiation_enable, negotiation_restart, sublayer_main_reset,
		input local_ability_word, isolate, loopback, unidir,
		input txd, tx_en, tx_er, reg_request, reg_write,
		output negotiation_done, partner_ability_word, page_received_flag,
		output negotiated_link_good, pll_loss, reg_rdata, reg_rdata_valid,
		output rxd, rx_dv, rx_er
	);
	modport host (
		output negotiation_enable, negotiation_restart, sublayer_main_reset,
		output local_ability_word, isolate, loopback, unidir,
		output txd, tx_en, tx_er, reg_request, reg_write,
		input negotiation_done, partner_ability_word, page_received_flag,
		input negotiated_link_good, pll_loss, reg_rdata, reg_rdata_valid,
		input rxd, rx_dv, rx_er
	);
endinterface : gpcs_if
`default_nettype wire

/* File: core/gpcs_dev.sv */
// Purpose: control and status end of the gigabit coding sublayer
// Assumes: serial transceiver gives code-groups and sync synchronous to clk
// Notes: auto-negotiation is a reduced form of the standard arbitration
`timescale 1ns/10ps
`default_nettype none
module gpcs_dev #(
	parameter int LINK_CYCLES = gpcs_pkg::LINK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// host side
	gpcs_if.dev bus,
	// transceiver side
	input wire logic [9:0] rx_code_i,
	input wire logic rx_sync_i,
	input wire logic pll_lock_i,
	output logic [9:0] tx_code_o
);
	// last timer value before expiry, cut to the counter width
	localparam logic [19:0] TIMER_END = 20'(LINK_CYCLES - 1);
	// enum alias keeps the package as the single owner of the type
	typedef gpcs_pkg::gpcs_an_e gpcs_an_e_t;

	// sampled mode controls
	logic iso_reg, lpb_reg, uni_reg;
	// negotiation and transmit state
	gpcs_an_e_t an_reg, an_next;
	logic [19:0] timer_reg, timer_next;
	logic [15:0] partner_reg, partner_next;
	logic half_reg, half_next;
	logic [9:0] tx_reg, tx_next;
	logic done_reg, done_next;
	logic page_reg, page_next;
	logic link_reg, link_next;
	// receive side state
	logic [7:0] lo_reg, lo_next;
	logic [15:0] cand_reg, cand_next;
	logic [1:0] match_reg, match_next;
	logic idle_reg, idle_next;
	logic [7:0] rxd_reg, rxd_next;
	logic dv_reg, dv_next, er_reg, er_next;
	logic plol_reg, rvalid_reg, rvalid_next;
	logic [15:0] rdata_reg, rdata_next;
	// combinational helpers
	logic [9:0] rx_cg;
	logic rx_sync;
	logic cfg_seen, cfg_ok, link_st, tx_ignore;
	logic [7:0] gtxd;
	logic gtx_en, gtx_er;
	logic [15:0] cfg_word;

	// one code-group with its kind and byte
	function automatic logic [9:0] gpcs_cg(input logic [1:0] k,
		input logic [7:0] b);
		gpcs_cg = {k, b};
	endfunction : gpcs_cg

	// loopback path replaces the transceiver input
	always_comb begin
		rx_cg = lpb_reg ? tx_reg : rx_code_i;
		rx_sync = lpb_reg ? 1'b1 : rx_sync_i;
		cfg_seen = rx_cg[gpcs_pkg::KIND_MSB:gpcs_pkg::KIND_LSB] ==
			gpcs_pkg::KIND_CFG_HI;
		cfg_word = {rx_cg[7:0], lo_reg};
		cfg_ok = match_reg == gpcs_pkg::CFG_MATCH;
		link_st = (an_reg == gpcs_pkg::AN_LINK_GOOD_ST) ||
			(an_reg == gpcs_pkg::AN_NO_NEG_GOOD_ST);
		// isolated transmit inputs act as all zero
		gtxd = iso_reg ? 8'h00 : bus.txd;
		gtx_en = iso_reg ? 1'b0 : bus.tx_en;
		gtx_er = iso_reg ? 1'b0 : bus.tx_er;
		// faults only gate transmit outside unidirectional mode
		tx_ignore = !uni_reg && (!link_st || !rx_sync);
	end

	// negotiation and transmit next state
	always_comb begin
		an_next = an_reg;
		timer_next = (timer_reg == TIMER_END) ? timer_reg : timer_reg + 20'h1;
		partner_next = partner_reg;
		half_next = 1'b0;
		tx_next = gpcs_cg(gpcs_pkg::KIND_IDLE, gpcs_pkg::IDLE_BYTE);
		case (an_reg)
			gpcs_pkg::AN_ENABLE_ST: begin
				an_next = bus.negotiation_enable ? gpcs_pkg::AN_RESTART_ST :
					gpcs_pkg::AN_NO_NEG_GOOD_ST;
				timer_next = 20'h0;
			end
			gpcs_pkg::AN_RESTART_ST: begin
				// zero config word while the partner notices the break
				if (timer_reg == TIMER_END) begin
					an_next = gpcs_pkg::AN_ABILITY_ST;
				end
			end
			gpcs_pkg::AN_ABILITY_ST: begin
				if (cfg_ok && cand_reg != gpcs_pkg::ABIL_RST) begin
					partner_next = cand_reg;
					an_next = gpcs_pkg::AN_ACK_ST;
				end
			end
			gpcs_pkg::AN_ACK_ST: begin
				if (cfg_ok && cand_reg[gpcs_pkg::ACK_BIT]) begin
					an_next = gpcs_pkg::AN_COMPLETE_ACK_ST;
					timer_next = 20'h0;
				end
			end
			gpcs_pkg::AN_COMPLETE_ACK_ST: begin
				if (timer_reg == TIMER_END) begin
					an_next = gpcs_pkg::AN_IDLE_ST;
					timer_next = 20'h0;
				end
			end
			gpcs_pkg::AN_IDLE_ST: begin
				// partner still configuring sends us back to ability
				if (cfg_seen) begin
					an_next = gpcs_pkg::AN_ABILITY_ST;
				end else if (timer_reg == TIMER_END && idle_reg) begin
					an_next = gpcs_pkg::AN_LINK_GOOD_ST;
				end
			end
			gpcs_pkg::AN_LINK_GOOD_ST: begin
				// renewed configuration from the partner restarts
				if (cfg_seen) begin
					an_next = gpcs_pkg::AN_RESTART_ST;
					timer_next = 20'h0;
				end
			end
			gpcs_pkg::AN_NO_NEG_GOOD_ST: begin
				an_next = gpcs_pkg::AN_NO_NEG_GOOD_ST;
			end
			default: begin
				an_next = gpcs_pkg::AN_ENABLE_ST;
			end
		endcase
		// lost sync while negotiating restarts the exchange
		if (bus.negotiation_enable && !rx_sync && !lpb_reg &&
			an_reg != gpcs_pkg::AN_RESTART_ST) begin
			an_next = gpcs_pkg::AN_RESTART_ST;
			timer_next = 20'h0;
		end
		if (bus.negotiation_restart && bus.negotiation_enable) begin
			an_next = gpcs_pkg::AN_RESTART_ST;
			timer_next = 20'h0;
		end
		if (!bus.negotiation_enable) begin
			an_next = gpcs_pkg::AN_NO_NEG_GOOD_ST;
		end else if (an_reg == gpcs_pkg::AN_NO_NEG_GOOD_ST) begin
			an_next = gpcs_pkg::AN_RESTART_ST;
			timer_next = 20'h0;
		end
		if (bus.sublayer_main_reset) begin
			an_next = gpcs_pkg::AN_ENABLE_ST;
			partner_next = gpcs_pkg::ABIL_RST;
		end
		// transmit code-group choice
		if (!uni_reg && (an_reg == gpcs_pkg::AN_RESTART_ST ||
			an_reg == gpcs_pkg::AN_ABILITY_ST || an_reg == gpcs_pkg::AN_ACK_ST ||
			an_reg == gpcs_pkg::AN_COMPLETE_ACK_ST)) begin
			half_next = !half_reg;
			tx_next = gpcs_cfg_cg(an_reg, half_reg, bus.local_ability_word);
		end else if (tx_ignore) begin
			tx_next = gpcs_cg(gpcs_pkg::KIND_IDLE, gpcs_pkg::IDLE_BYTE);
		end else if (gtx_er) begin
			tx_next = gpcs_cg(gpcs_pkg::KIND_IDLE, gpcs_pkg::ERR_BYTE);
		end else if (gtx_en) begin
			tx_next = gpcs_cg(gpcs_pkg::KIND_DATA, gtxd);
		end
		// status flags line up with the state they describe
		page_next = an_next == gpcs_pkg::AN_COMPLETE_ACK_ST;
		done_next = an_next == gpcs_pkg::AN_LINK_GOOD_ST;
		link_next = (an_next == gpcs_pkg::AN_LINK_GOOD_ST) ||
			(an_next == gpcs_pkg::AN_NO_NEG_GOOD_ST);
	end

	// configuration word halves: low byte then high byte
	// a function, so the ability word stays in the comb sensitivity
	function automatic logic [9:0] gpcs_cfg_cg(input gpcs_an_e_t st,
		input logic hi, input logic [15:0] abil);
		logic [15:0] w;
		w = (st == gpcs_pkg::AN_RESTART_ST) ? gpcs_pkg::ABIL_RST : abil;
		if (st == gpcs_pkg::AN_ACK_ST || st == gpcs_pkg::AN_COMPLETE_ACK_ST) begin
			w[gpcs_pkg::ACK_BIT] = 1'b1;
		end
		gpcs_cfg_cg = hi ? gpcs_cg(gpcs_pkg::KIND_CFG_HI, w[15:8]) :
			gpcs_cg(gpcs_pkg::KIND_CFG_LO, w[7:0]);
	endfunction : gpcs_cfg_cg

	// receive decode, word matching and register answer
	always_comb begin
		lo_next = lo_reg;
		cand_next = cand_reg;
		match_next = match_reg;
		idle_next = rx_cg[gpcs_pkg::KIND_MSB:gpcs_pkg::KIND_LSB] ==
			gpcs_pkg::KIND_IDLE;
		if (rx_cg[gpcs_pkg::KIND_MSB:gpcs_pkg::KIND_LSB] ==
			gpcs_pkg::KIND_CFG_LO) begin
			lo_next = rx_cg[7:0];
		end
		// count identical consecutive configuration words
		if (cfg_seen) begin
			if (cfg_word == cand_reg) begin
				match_next = cfg_ok ? match_reg : match_reg + 2'h1;
			end else begin
				cand_next = cfg_word;
				match_next = 2'h1;
			end
		end else if (idle_next) begin
			match_next = 2'h0;
		end
		rxd_next = 8'h00;
		dv_next = 1'b0;
		er_next = 1'b0;
		if (rx_cg[gpcs_pkg::KIND_MSB:gpcs_pkg::KIND_LSB] ==
			gpcs_pkg::KIND_DATA) begin
			rxd_next = rx_cg[7:0];
			dv_next = 1'b1;
		end else if (idle_next && rx_cg[7:0] == gpcs_pkg::ERR_BYTE) begin
			er_next = 1'b1;
		end
		// isolation zeroes the values but the outputs stay driven
		if (iso_reg || bus.sublayer_main_reset) begin
			rxd_next = 8'h00;
			dv_next = 1'b0;
			er_next = 1'b0;
		end
		if (bus.sublayer_main_reset) begin
			match_next = 2'h0;
		end
		// reads return the partner word one cycle after the request
		rvalid_next = bus.reg_request && !bus.reg_write;
		rdata_next = rvalid_next ? partner_reg : rdata_reg;
	end

	// registers; the mode controls are plain flops in the core domain
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			iso_reg <= 1'b0;
			lpb_reg <= 1'b0;
			uni_reg <= 1'b0;
			an_reg <= gpcs_pkg::AN_ENABLE_ST;
			timer_reg <= 20'h0;
			partner_reg <= gpcs_pkg::ABIL_RST;
			half_reg <= 1'b0;
			tx_reg <= gpcs_pkg::CG_RST;
			done_reg <= 1'b0;
			page_reg <= 1'b0;
			link_reg <= 1'b0;
			lo_reg <= 8'h00;
			cand_reg <= gpcs_pkg::ABIL_RST;
			match_reg <= 2'h0;
			idle_reg <= 1'b0;
			rxd_reg <= 8'h00;
			dv_reg <= 1'b0;
			er_reg <= 1'b0;
			plol_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= gpcs_pkg::ABIL_RST;
		end else begin
			iso_reg <= bus.isolate;
			lpb_reg <= bus.loopback;
			uni_reg <= bus.unidir;
			an_reg <= an_next;
			timer_reg <= timer_next;
			partner_reg <= partner_next;
			half_reg <= half_next;
			tx_reg <= tx_next;
			done_reg <= done_next;
			page_reg <= page_next;
			link_reg <= link_next;
			lo_reg <= lo_next;
			cand_reg <= cand_next;
			match_reg <= match_next;
			idle_reg <= idle_next;
			rxd_reg <= rxd_next;
			dv_reg <= dv_next;
			er_reg <= er_next;
			plol_reg <= !pll_lock_i;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
		end
	end

	// outputs straight from flops
	assign tx_code_o = tx_reg;
	assign bus.negotiation_done = done_reg;
	assign bus.partner_ability_word = partner_reg;
	assign bus.page_received_flag = page_reg;
	assign bus.negotiated_link_good = link_reg;
	assign bus.pll_loss = plol_reg;
	assign bus.reg_rdata = rdata_reg;
	assign bus.reg_rdata_valid = rvalid_reg;
	assign bus.rxd = rxd_reg;
	assign bus.rx_dv = dv_reg;
	assign bus.rx_er = er_reg;
endmodule : gpcs_dev
`default_nettype wire

/* File: core/gpcs_host.sv */
// Purpose: MAC and management end facing the coding sublayer
// Assumes: user-side inputs synchronous to clk_sys_i
// Notes: every value sent to the sublayer is registered here first
`timescale 1ns/10ps
`default_nettype none
module gpcs_host (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// sublayer side
	gpcs_if.host bus,
	// user controls
	input wire logic an_enable_i,
	input wire logic an_restart_i,
	input wire logic main_reset_i,
	input wire logic [15:0] ability_i,
	input wire logic isolate_i,
	input wire logic loopback_i,
	input wire logic unidir_i,
	// user transmit (G)MII
	input wire logic [7:0] txd_i,
	input wire logic tx_en_i,
	input wire logic tx_er_i,
	// user register command
	input wire logic cmd_start_i,
	input wire logic cmd_write_i,
	// user status
	output logic link_status_o,
	output logic [7:0] rxd_o,
	output logic rx_dv_o,
	output logic rx_er_o
);
	// registered controls and transmit data
	logic en_reg, rst_an_reg, mrst_reg, iso_reg, lpb_reg, uni_reg;
	logic [15:0] abil_reg;
	logic [7:0] txd_reg, rxd_reg;
	logic txen_reg, txer_reg, dv_reg, er_reg;
	// register command pulse and direction
	logic req_reg, req_next, wr_reg;
	logic stat_reg, stat_next;

	// request pulses on every other cycle while start is held; status follows link good
	always_comb begin
		req_next = cmd_start_i && !req_reg;
		// unused features simply hold their inputs low at the user side
		stat_next = bus.negotiated_link_good;
	end

	// host registers
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			en_reg <= 1'b0;
			rst_an_reg <= 1'b0;
			mrst_reg <= 1'b1;
			iso_reg <= 1'b0;
			lpb_reg <= 1'b0;
			uni_reg <= 1'b0;
			abil_reg <= gpcs_pkg::ABIL_RST;
			txd_reg <= 8'h00;
			txen_reg <= 1'b0;
			txer_reg <= 1'b0;
			req_reg <= 1'b0;
			wr_reg <= 1'b0;
			stat_reg <= 1'b0;
			rxd_reg <= 8'h00;
			dv_reg <= 1'b0;
			er_reg <= 1'b0;
		end else begin
			en_reg <= an_enable_i;
			rst_an_reg <= an_restart_i;
			mrst_reg <= main_reset_i;
			iso_reg <= isolate_i;
			lpb_reg <= loopback_i;
			uni_reg <= unidir_i;
			abil_reg <= ability_i;
			txd_reg <= txd_i;
			txen_reg <= tx_en_i;
			txer_reg <= tx_er_i;
			req_reg <= req_next;
			wr_reg <= cmd_write_i;
			stat_reg <= stat_next;
			rxd_reg <= bus.rxd;
			dv_reg <= bus.rx_dv;
			er_reg <= bus.rx_er;
		end
	end

	// drive the sublayer and the user from flops
	assign bus.negotiation_enable = en_reg;
	assign bus.negotiation_restart = rst_an_reg;
	assign bus.sublayer_main_reset = mrst_reg;
	assign bus.local_ability_word = abil_reg;
	assign bus.isolate = iso_reg;
	assign bus.loopback = lpb_reg;
	assign bus.unidir = uni_reg;
	assign bus.txd = txd_reg;
	assign bus.tx_en = txen_reg;
	assign bus.tx_er = txer_reg;
	assign bus.reg_request = req_reg;
	assign bus.reg_write = wr_reg;
	assign link_status_o = stat_reg;
	assign rxd_o = rxd_reg;
	assign rx_dv_o = dv_reg;
	assign rx_er_o = er_reg;
endmodule : gpcs_host
`default_nettype wire

/* File: tb/gpcs_assertions.sv */
// Purpose: concurrent checks on the link between host and sublayer
// Assumes: one core clock, asynchronous active-low reset
// Notes: watches interface signals plus two transceiver pins
`timescale 1ns/10ps
`default_nettype none
module gpcs_assertions (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// host controls
	input wire logic negotiation_enable,
	input wire logic negotiation_restart,
	input wire logic sublayer_main_reset,
	input wire logic isolate,
	input wire logic reg_request,
	input wire logic reg_write,
	// sublayer status
	input wire logic negotiation_done,
	input wire logic [15:0] partner_ability_word,
	input wire logic page_received_flag,
	input wire logic negotiated_link_good,
	input wire logic pll_loss,
	input wire logic reg_rdata_valid,
	input wire logic [7:0] rxd,
	input wire logic rx_dv,
	input wire logic rx_er,
	// transceiver pins
	input wire logic pll_lock_i,
	input wire logic [9:0] tx_code_o
);
	// single domain, so clock and disable are given once
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);
	property p_done;
		negotiation_done |-> negotiated_link_good && !page_received_flag;
	endproperty
	a_done: assert property (p_done) else $error("done off link good");
	property p_page;
		page_received_flag |-> !negotiated_link_good && !negotiation_done;
	endproperty
	a_page: assert property (p_page) else $error("page flag in link");
	// idle wait must pass before link good, unless enable drops
	property p_idle_wait;
		$fell(page_received_flag) ##0 negotiation_enable [*8]
			|-> !negotiated_link_good;
	endproperty
	a_idle_wait: assert property (p_idle_wait) else $error("idle cut short");
	property p_noneg;
		(!negotiation_enable && !negotiation_restart && !sublayer_main_reset)
			[*3] |-> negotiated_link_good && !negotiation_done;
	endproperty
	a_noneg: assert property (p_noneg) else $error("no-neg link low");
	property p_restart;
		(negotiation_restart && negotiation_enable && !sublayer_main_reset) [*2]
			|-> !negotiated_link_good && !page_received_flag;
	endproperty
	a_restart: assert property (p_restart) else $error("restart ignored");
	property p_mreset;
		sublayer_main_reset |=> partner_ability_word == 16'h0000 &&
			!rx_dv && !negotiated_link_good;
	endproperty
	a_mreset: assert property (p_mreset) else $error("main reset ignored");
	property p_iso_rx;
		isolate [*3] |-> rxd == 8'h00 && !rx_dv && !rx_er;
	endproperty
	a_iso_rx: assert property (p_iso_rx) else $error("isolated rx not zero");
	property p_iso_tx;
		isolate [*3] |-> tx_code_o[9:8] != gpcs_pkg::KIND_DATA;
	endproperty
	a_iso_tx: assert property (p_iso_tx) else $error("isolated tx sent data");
	property p_read;
		reg_request && !reg_write |=> reg_rdata_valid ##1 !reg_rdata_valid;
	endproperty
	a_read: assert property (p_read) else $error("read not answered");
	property p_write;
		reg_request && reg_write |=> !reg_rdata_valid;
	endproperty
	a_write: assert property (p_write) else $error("write answered");
	property p_pll;
		$changed(pll_lock_i) |=> pll_loss == !$past(pll_lock_i);
	endproperty
	a_pll: assert property (p_pll) else $error("pll flag wrong");
endmodule : gpcs_assertions
`default_nettype wire

/* File: tb/gpcs_tb.sv */
// Purpose: self-checking bench joining the host and sublayer ends
// Assumes: 50 MHz clock, link timer shortened to 16 cycles
// Notes: negotiation runs against itself through loopback
`timescale 1ns/10ps
`default_nettype none
module gpcs_tb;
	// one steady table row: inputs and expected code and valid
	typedef struct packed {
		logic [7:0] d;
		logic en;
		logic er;
		logic [9:0] code;
		logic dv;
	} gpcs_row_s;
	// ability word carries the ack bit, so both accepted forms match
	localparam logic [15:0] ABIL = 16'h41A0;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic an_en, an_rst, m_rst, iso, lpb, uni, en, er, start, wr;
	logic [15:0] ability;
	logic [7:0] txd, rxd;
	logic [9:0] rx_code, tx_code;
	logic sync, lock, link_st, rx_dv, rx_er;
	logic saw_page = 1'b0;
	int checks = 0;
	int n_errors = 0;
	// data kind 1 above the byte, idle kind 0 with idle or error byte
	gpcs_row_s rows [4] = '{
		'{8'h55, 1'b1, 1'b0, 10'h155, 1'b1},
		'{8'hC3, 1'b1, 1'b0, 10'h1C3, 1'b1},
		'{8'h7E, 1'b0, 1'b0, 10'h000, 1'b0},
		'{8'h7E, 1'b0, 1'b1, 10'h0FE, 1'b0}
	};
	gpcs_if i_gpcs_if ();
	gpcs_host i_gpcs_host (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.bus(i_gpcs_if), .an_enable_i(an_en), .an_restart_i(an_rst),
		.main_reset_i(m_rst), .ability_i(ability), .isolate_i(iso),
		.loopback_i(lpb), .unidir_i(uni), .txd_i(txd), .tx_en_i(en),
		.tx_er_i(er), .cmd_start_i(start), .cmd_write_i(wr),
		.link_status_o(link_st), .rxd_o(rxd), .rx_dv_o(rx_dv),
		.rx_er_o(rx_er));
	gpcs_dev #(.LINK_CYCLES(16)) i_gpcs_dev (.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i), .bus(i_gpcs_if), .rx_code_i(rx_code),
		.rx_sync_i(sync), .pll_lock_i(lock), .tx_code_o(tx_code));
	gpcs_assertions i_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.negotiation_enable(i_gpcs_if.negotiation_enable),
		.negotiation_restart(i_gpcs_if.negotiation_restart),
		.sublayer_main_reset(i_gpcs_if.sublayer_main_reset),
		.isolate(i_gpcs_if.isolate), .reg_request(i_gpcs_if.reg_request),
		.reg_write(i_gpcs_if.reg_write),
		.negotiation_done(i_gpcs_if.negotiation_done),
		.partner_ability_word(i_gpcs_if.partner_ability_word),
		.page_received_flag(i_gpcs_if.page_received_flag),
		.negotiated_link_good(i_gpcs_if.negotiated_link_good),
		.pll_loss(i_gpcs_if.pll_loss),
		.reg_rdata_valid(i_gpcs_if.reg_rdata_valid), .rxd(i_gpcs_if.rxd),
		.rx_dv(i_gpcs_if.rx_dv), .rx_er(i_gpcs_if.rx_er),
		.pll_lock_i(lock), .tx_code_o(tx_code));
	// free-running core clock
	always #10 clk_sys_i = ~clk_sys_i;
	// remember that the page flag was ever seen
	always @(posedge clk_sys_i) begin
		if (i_gpcs_if.page_received_flag === 1'b1) saw_page <= 1'b1;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : step
	// looks just after an edge, once its updates have landed
	task automatic look(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : look
	task automatic summarize();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	task automatic chk_bit(input logic got, input logic exp, input string m);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask : chk_bit
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
		input string m);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask : chk_word
	// bounded wait for the link level; running out ends the run
	task automatic wait_link(input logic exp);
		int i;
		for (i = 0; i < 400; i++) begin
			if (i_gpcs_if.negotiated_link_good === exp) break;
			look(1);
		end
		chk_bit(i < 400, 1'b1, "link wait ran out");
		if (i >= 400) summarize();
	endtask : wait_link
	initial begin
		int i;
		{an_en, an_rst, iso, lpb, uni, en, er, start, wr} = 9'h000;
		m_rst = 1'b1;
		ability = 16'h0000;
		txd = 8'h00;
		rx_code = 10'h13C;
		sync = 1'b1;
		lock = 1'b1;
		look(3);
		chk_bit(i_gpcs_if.pll_loss, 1'b1, "pll flag in reset");
		step(1);
		resetn_i <= 1'b1;
		m_rst <= 1'b0;
		an_en <= 1'b1;
		ability <= ABIL;
		lpb <= 1'b1;
		wait_link(1'b1);
		chk_bit(i_gpcs_if.negotiation_done, 1'b1, "done");
		chk_word(i_gpcs_if.partner_ability_word, ABIL, "partner");
		chk_bit(saw_page, 1'b1, "page flag never seen");
		look(1);
		chk_bit(link_st, 1'b1, "link status");
		// one read then one write through the host pulse
		step(1);
		start <= 1'b1;
		step(1);
		start <= 1'b0;
		for (i = 0; i < 8 && i_gpcs_if.reg_rdata_valid !== 1'b1; i++) look(1);
		chk_bit(i < 8, 1'b1, "read answer ran out");
		if (i >= 8) summarize();
		chk_word(i_gpcs_if.reg_rdata, ABIL, "read data");
		step(1);
		wr <= 1'b1;
		start <= 1'b1;
		step(1);
		start <= 1'b0;
		// steady data through loopback, one row at a time
		foreach (rows[k]) begin
			step(1);
			txd <= rows[k].d;
			en <= rows[k].en;
			er <= rows[k].er;
			look(6);
			chk_word({6'h00, tx_code}, {6'h00, rows[k].code}, "tx");
			chk_bit(rx_dv, rows[k].dv, "rx valid");
			chk_bit(rx_er, rows[k].er, "rx error");
			if (rows[k].dv) chk_word({8'h00, rxd}, {8'h00, rows[k].d}, "rx");
		end
		step(1);
		iso <= 1'b1;
		er <= 1'b0;
		txd <= 8'h5A;
		en <= 1'b1;
		look(6);
		chk_word({6'h00, i_gpcs_if.rx_dv, i_gpcs_if.rx_er, i_gpcs_if.rxd},
			16'h0000, "isolated rx");
		chk_word({6'h00, tx_code}, 16'h0000, "isolated tx");
		step(1);
		iso <= 1'b0;
		look(6);
		chk_word({8'h00, rxd}, 16'h005A, "rx after isolate");
		step(1);
		an_rst <= 1'b1;
		look(4);
		chk_bit(i_gpcs_if.negotiated_link_good, 1'b0, "restart");
		step(1);
		an_rst <= 1'b0;
		wait_link(1'b1);
		// loopback off: the receiver sees the transceiver again
		step(1);
		lpb <= 1'b0;
		look(6);
		chk_word({7'h00, rx_dv, rxd}, 16'h013C, "rx from line");
		chk_word({6'h00, tx_code}, 16'h015A, "tx still data");
		step(1);
		an_en <= 1'b0;
		look(4);
		chk_bit(i_gpcs_if.negotiated_link_good, 1'b1, "no-neg link");
		chk_bit(i_gpcs_if.negotiation_done, 1'b0, "no-neg done");
		step(1);
		an_en <= 1'b1;
		look(4);
		chk_bit(i_gpcs_if.negotiated_link_good, 1'b0, "re-enable");
		// sync lost: data held back until unidirectional is set
		step(1);
		sync <= 1'b0;
		look(6);
		chk_bit(tx_code[9:8] == 2'h1, 1'b0, "tx data without sync");
		step(1);
		uni <= 1'b1;
		look(6);
		chk_word({6'h00, tx_code}, 16'h015A, "unidirectional tx");
		chk_bit(i_gpcs_if.negotiated_link_good, 1'b0, "unidir link");
		step(1);
		m_rst <= 1'b1;
		look(4);
		chk_word(i_gpcs_if.partner_ability_word, 16'h0000, "main reset");
		step(1);
		lock <= 1'b0;
		look(3);
		chk_bit(i_gpcs_if.pll_loss, 1'b1, "pll lost");
		step(1);
		lock <= 1'b1;
		look(3);
		chk_bit(i_gpcs_if.pll_loss, 1'b0, "pll relocked");
		summarize();
	end
endmodule : gpcs_tb
`default_nettype wire
